// File: rtl/idt_pkg.sv
// Purpose: Shared constants, encodings and carriers for instruction decode and timing
// Assumes: 14-bit instruction words, 7-bit file addresses, 8-bit data path
// Notes:   Constants, encodings and carriers only, no logic
// Function
// - Accept 14-bit words of opcode plus operands
// - Sort words into byte, bit, literal/control
// - Destination bit zero to accumulator, one file
// - File address spans 0x00 through 0x7F
// - Bit operand picks bit, file field picks register
// - Constant is 8-bit immediate or 11-bit target
// - Don't-care opcode bits never change decoding
// - One cycle; taken skip or jump adds NOP
// - Instruction cycle is four oscillator periods
// - Port read-modify-write sources live pin values
// - Timer write clears prescaler when assigned there
package idt_pkg;
   localparam int INSTR_W       = 14;
   localparam int FILE_W        = 7;
   localparam int DATA_W        = 8;
   localparam int BIT_W         = 3;
   localparam int LIT8_W        = 8;
   localparam int LIT11_W       = 11;
   localparam int DEST_POS      = 7;
   localparam int FILE_LSB      = 0;
   localparam int BIT_LSB       = 7;
   localparam int OSC_PER_CYCLE = 4;
   localparam int PHASE_W       = 2;
   localparam logic [FILE_W-1:0]  FILE_MIN  = 7'h00;
   localparam logic [FILE_W-1:0]  FILE_MAX  = 7'h7F;
   localparam logic [INSTR_W-1:0] NOP_WORD  = 14'h0000;
   localparam logic [PHASE_W-1:0] PH_Q1     = 2'h0;
   localparam logic [PHASE_W-1:0] PH_Q2     = 2'h1;
   localparam logic [PHASE_W-1:0] PH_Q3     = 2'h2;
   localparam logic [PHASE_W-1:0] PH_Q4     = 2'h3;
   localparam logic [PHASE_W-1:0] PH_STEP   = 2'h1;
   // Encodings, question marks are don't-care positions
   localparam logic [INSTR_W-1:0] P_ADDWF  = 14'h07??;
   localparam logic [INSTR_W-1:0] P_ANDWF  = 14'h05??;
   localparam logic [INSTR_W-1:0] P_CLRF   = 14'b00_0001_1???_????;
   localparam logic [INSTR_W-1:0] P_CLRW   = 14'h0103;
   localparam logic [INSTR_W-1:0] P_COMF   = 14'h09??;
   localparam logic [INSTR_W-1:0] P_DECF   = 14'h03??;
   localparam logic [INSTR_W-1:0] P_DECSZ  = 14'h0B??;
   localparam logic [INSTR_W-1:0] P_INCF   = 14'h0A??;
   localparam logic [INSTR_W-1:0] P_INCSZ  = 14'h0F??;
   localparam logic [INSTR_W-1:0] P_IORWF  = 14'h04??;
   localparam logic [INSTR_W-1:0] P_MOVF   = 14'h08??;
   localparam logic [INSTR_W-1:0] P_MOVWF  = 14'b00_0000_1???_????;
   localparam logic [INSTR_W-1:0] P_NOP    = 14'b00_0000_0??0_0000;
   localparam logic [INSTR_W-1:0] P_RLF    = 14'h0D??;
   localparam logic [INSTR_W-1:0] P_RRF    = 14'h0C??;
   localparam logic [INSTR_W-1:0] P_SUBWF  = 14'h02??;
   localparam logic [INSTR_W-1:0] P_SWAPF  = 14'h0E??;
   localparam logic [INSTR_W-1:0] P_XORWF  = 14'h06??;
   localparam logic [INSTR_W-1:0] P_BCF    = 14'b01_00??_????_????;
   localparam logic [INSTR_W-1:0] P_BSF    = 14'b01_01??_????_????;
   localparam logic [INSTR_W-1:0] P_BTFSC  = 14'b01_10??_????_????;
   localparam logic [INSTR_W-1:0] P_BTFSS  = 14'b01_11??_????_????;
   localparam logic [INSTR_W-1:0] P_RETFIE = 14'h0009;
   localparam logic [INSTR_W-1:0] P_RETURN = 14'h0008;
   localparam logic [INSTR_W-1:0] P_CLRWDT = 14'h0064;
   localparam logic [INSTR_W-1:0] P_SLEEP  = 14'h0063;
   localparam logic [INSTR_W-1:0] P_CALL   = 14'b10_0???_????_????;
   localparam logic [INSTR_W-1:0] P_GOTO   = 14'b10_1???_????_????;
   localparam logic [INSTR_W-1:0] P_MOVLW  = 14'b11_00??_????_????;
   localparam logic [INSTR_W-1:0] P_RETLW  = 14'b11_01??_????_????;
   localparam logic [INSTR_W-1:0] P_IORLW  = 14'h38??;
   localparam logic [INSTR_W-1:0] P_ANDLW  = 14'h39??;
   localparam logic [INSTR_W-1:0] P_SUBLW  = 14'b11_110?_????_????;
   localparam logic [INSTR_W-1:0] P_ADDLW  = 14'b11_111?_????_????;

   typedef enum logic [1:0] {FMT_BYTE, FMT_BIT, FMT_LITCTL} idt_fmt_type;

   typedef enum logic [5:0] {
      OP_NOP, OP_ADDWF, OP_ANDWF, OP_CLRF, OP_CLRW, OP_COMF, OP_DECF, OP_DECSZ,
      OP_INCF, OP_INCSZ, OP_IORWF, OP_MOVF, OP_MOVWF, OP_RLF, OP_RRF, OP_SUBWF,
      OP_SWAPF, OP_XORWF, OP_BCF, OP_BSF, OP_BTFSC, OP_BTFSS, OP_RETFIE,
      OP_RETURN, OP_CLRWDT, OP_SLEEP, OP_CALL, OP_GOTO, OP_MOVLW, OP_RETLW,
      OP_IORLW, OP_ANDLW, OP_SUBLW, OP_ADDLW, OP_BAD
   } idt_op_type;

   typedef struct packed {
      idt_fmt_type         fmt;
      idt_op_type          op;
      logic [FILE_W-1:0]   fileAddr;
      logic                toFile;
      logic [BIT_W-1:0]    bitPos;
      logic [LIT8_W-1:0]   lit8;
      logic [LIT11_W-1:0]  lit11;
      logic                writeAccum;
      logic                writeFile;
      logic                readsFile;
      logic                changesPc;
      logic                maySkip;
      logic                illegal;
   } idt_decode_type;

   typedef struct packed {
      logic [PHASE_W-1:0]  phase;
      logic                liveNext;
      logic [INSTR_W-1:0]  word;
      idt_decode_type      dec;
      logic [DATA_W-1:0]   pinMeta;
      logic [DATA_W-1:0]   pinSync;
      logic                fetchStrobe;
      logic                cycleStart;
      logic                execStrobe;
      logic                nopCycle;
      logic                writeAccum;
      logic                writeFile;
      logic                prescalerClear;
      logic                pcAltered;
      logic                illegalOp;
      logic [DATA_W-1:0]   srcOperand;
   } idt_state_type;
endpackage

// File: rtl/idt_field_decode.sv
// Purpose: Split one instruction word into format, operation and operand fields
// Assumes: Purely combinational, read by the timing core in its second phase
// Notes:   Unknown words come out as a no-write, no-branch bad operation
`timescale 1ns/1ps
module idt_field_decode
   import idt_pkg::*;
(
   input  wire logic [idt_pkg::INSTR_W-1:0] word,
   output idt_pkg::idt_decode_type          dec
);
   // Operand extraction, same positions for every format
   always_comb begin
      dec            = '0;
      dec.fileAddr   = word[FILE_LSB +: FILE_W];
      dec.toFile     = word[DEST_POS];
      dec.bitPos     = word[BIT_LSB +: BIT_W];
      dec.lit8       = word[LIT8_W-1:0];
      dec.lit11      = word[LIT11_W-1:0];
      // Pattern match, don't-care bits wildcarded
      casez (word)
         P_NOP:    dec.op = OP_NOP;
         P_RETURN: dec.op = OP_RETURN;
         P_RETFIE: dec.op = OP_RETFIE;
         P_CLRWDT: dec.op = OP_CLRWDT;
         P_SLEEP:  dec.op = OP_SLEEP;
         P_MOVWF:  dec.op = OP_MOVWF;
         P_CLRW:   dec.op = OP_CLRW;
         P_CLRF:   dec.op = OP_CLRF;
         P_ADDWF:  dec.op = OP_ADDWF;
         P_ANDWF:  dec.op = OP_ANDWF;
         P_COMF:   dec.op = OP_COMF;
         P_DECF:   dec.op = OP_DECF;
         P_DECSZ:  dec.op = OP_DECSZ;
         P_INCF:   dec.op = OP_INCF;
         P_INCSZ:  dec.op = OP_INCSZ;
         P_IORWF:  dec.op = OP_IORWF;
         P_MOVF:   dec.op = OP_MOVF;
         P_RLF:    dec.op = OP_RLF;
         P_RRF:    dec.op = OP_RRF;
         P_SUBWF:  dec.op = OP_SUBWF;
         P_SWAPF:  dec.op = OP_SWAPF;
         P_XORWF:  dec.op = OP_XORWF;
         P_BCF:    dec.op = OP_BCF;
         P_BSF:    dec.op = OP_BSF;
         P_BTFSC:  dec.op = OP_BTFSC;
         P_BTFSS:  dec.op = OP_BTFSS;
         P_CALL:   dec.op = OP_CALL;
         P_GOTO:   dec.op = OP_GOTO;
         P_MOVLW:  dec.op = OP_MOVLW;
         P_RETLW:  dec.op = OP_RETLW;
         P_IORLW:  dec.op = OP_IORLW;
         P_ANDLW:  dec.op = OP_ANDLW;
         P_SUBLW:  dec.op = OP_SUBLW;
         P_ADDLW:  dec.op = OP_ADDLW;
         default:  dec.op = OP_BAD;
      endcase
      // Format and result steering per operation
      dec.fmt = FMT_LITCTL;
      case (dec.op)
         OP_ADDWF, OP_ANDWF, OP_COMF, OP_DECF, OP_INCF, OP_IORWF, OP_MOVF,
         OP_RLF, OP_RRF, OP_SUBWF, OP_SWAPF, OP_XORWF, OP_DECSZ, OP_INCSZ: begin
            dec.fmt        = FMT_BYTE;
            dec.readsFile  = 1'b1;
            dec.writeAccum = ~dec.toFile;
            dec.writeFile  = dec.toFile;
            dec.maySkip    = (dec.op == OP_DECSZ) || (dec.op == OP_INCSZ);
         end
         OP_CLRF, OP_MOVWF: begin
            dec.fmt       = FMT_BYTE;
            dec.writeFile = 1'b1;
         end
         OP_CLRW, OP_NOP: begin
            dec.fmt        = FMT_BYTE;
            dec.writeAccum = (dec.op == OP_CLRW);
         end
         OP_BCF, OP_BSF: begin
            dec.fmt       = FMT_BIT;
            dec.readsFile = 1'b1;
            dec.writeFile = 1'b1;
         end
         OP_BTFSC, OP_BTFSS: begin
            dec.fmt       = FMT_BIT;
            dec.readsFile = 1'b1;
            dec.maySkip   = 1'b1;
         end
         OP_MOVLW, OP_IORLW, OP_ANDLW, OP_SUBLW, OP_ADDLW: dec.writeAccum = 1'b1;
         OP_RETLW: begin
            dec.writeAccum = 1'b1;
            dec.changesPc  = 1'b1;
         end
         OP_CALL, OP_GOTO, OP_RETURN, OP_RETFIE: dec.changesPc = 1'b1;
         OP_BAD:  dec.illegal = 1'b1;
         default: dec.illegal = 1'b0;
      endcase
   end
endmodule

// File: rtl/idt_core.sv
// Purpose: Instruction cycle sequencer with decode, result routing and skip handling
// Assumes: ref_clk is the oscillator; the word source and file data share this clock
// Notes:   Four clock phases form one instruction cycle; flushed cycles run as NOP
`timescale 1ns/1ps
module idt_core
   import idt_pkg::*;
#(
   parameter logic [idt_pkg::FILE_W-1:0] TIMER_ADDR = 7'h01,
   parameter logic [idt_pkg::FILE_W-1:0] PCL_ADDR   = 7'h02,
   parameter logic [idt_pkg::FILE_W-1:0] PORT_ADDR  = 7'h06
)
(
   input  wire logic                        ref_clk,
   input  wire logic                        sys_rst,
   input  wire logic [idt_pkg::INSTR_W-1:0] instrWord,
   input  wire logic                        skipTrue,
   input  wire logic                        prescalerOnTimer,
   input  wire logic [idt_pkg::DATA_W-1:0]  fileData,
   input  wire logic [idt_pkg::DATA_W-1:0]  portPins,
   output idt_pkg::idt_decode_type          decoded,
   output logic                             fetchStrobe,
   output logic                             cycleStart,
   output logic                             execStrobe,
   output logic                             nopCycle,
   output logic                             writeAccum,
   output logic                             writeFile,
   output logic                             prescalerClear,
   output logic                             pcAltered,
   output logic                             illegalOp,
   output logic [idt_pkg::DATA_W-1:0]       srcOperand
);
   import idt_pkg::*;

   idt_state_type  state_r;
   idt_state_type  state_nxt;
   idt_decode_type fieldDec;
   logic           hitTimer;
   logic           hitPcl;
   logic           hitPort;
   logic           pcWrite;

   // Field splitter works on the word latched in the first phase
   idt_field_decode u_field_decode (
      .word (state_r.word),
      .dec  (fieldDec)
   );

   // Address compares on the decoded file field
   assign hitTimer = (state_r.dec.fileAddr == TIMER_ADDR);
   assign hitPcl   = (state_r.dec.fileAddr == PCL_ADDR);
   assign hitPort  = (state_r.dec.fileAddr == PORT_ADDR);
   // A file write to the low program counter byte also redirects flow
   assign pcWrite  = state_r.dec.changesPc || (state_r.dec.writeFile && hitPcl);

   // Next state: phase sequencer and the work of each phase
   always_comb begin
      state_nxt                = state_r;
      state_nxt.fetchStrobe    = 1'b0;
      state_nxt.cycleStart     = 1'b0;
      state_nxt.execStrobe     = 1'b0;
      state_nxt.writeAccum     = 1'b0;
      state_nxt.writeFile      = 1'b0;
      state_nxt.prescalerClear = 1'b0;
      // Pin synchroniser, first stage feeds only the second
      state_nxt.pinMeta        = portPins;
      state_nxt.pinSync        = state_r.pinMeta;
      // Four oscillator periods per instruction cycle
      state_nxt.phase          = state_r.phase + PH_STEP;
      case (state_r.phase)
         PH_Q1: begin
            // Latch the presented word, or a NOP after a skip or jump
            state_nxt.cycleStart = 1'b1;
            state_nxt.nopCycle   = ~state_r.liveNext;
            state_nxt.word       = state_r.liveNext ? instrWord : NOP_WORD;
            state_nxt.liveNext   = 1'b1;
         end
         PH_Q2: begin
            // Capture the split fields
            state_nxt.dec        = fieldDec;
            state_nxt.illegalOp  = fieldDec.illegal;
         end
         PH_Q3: begin
            // Port read-modify-write takes the pins, not the latch
            if (state_r.dec.readsFile && hitPort) begin
               state_nxt.srcOperand = state_r.pinSync;
            end else begin
               state_nxt.srcOperand = fileData;
            end
         end
         PH_Q4: begin
            // Commit results and decide on the extra NOP cycle
            state_nxt.execStrobe     = 1'b1;
            state_nxt.fetchStrobe    = 1'b1;
            state_nxt.writeAccum     = state_r.dec.writeAccum;
            state_nxt.writeFile      = state_r.dec.writeFile;
            state_nxt.prescalerClear = state_r.dec.writeFile && hitTimer
                                       && prescalerOnTimer;
            state_nxt.pcAltered      = pcWrite;
            state_nxt.liveNext       = ~(pcWrite
                                       || (state_r.dec.maySkip && skipTrue));
         end
         default: begin
            state_nxt.phase = PH_Q1;
         end
      endcase
   end

   // State register; reset starts with a flushed cycle
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Outputs straight from the state register
   assign decoded        = state_r.dec;
   assign fetchStrobe    = state_r.fetchStrobe;
   assign cycleStart     = state_r.cycleStart;
   assign execStrobe     = state_r.execStrobe;
   assign nopCycle       = state_r.nopCycle;
   assign writeAccum     = state_r.writeAccum;
   assign writeFile      = state_r.writeFile;
   assign prescalerClear = state_r.prescalerClear;
   assign pcAltered      = state_r.pcAltered;
   assign illegalOp      = state_r.illegalOp;
   assign srcOperand     = state_r.srcOperand;

endmodule

// File: verification/idt_core_checker.sv
// Purpose: Port assertions for the decode and timing core
// Assumes: One clock, asynchronous reset active high
// Notes:   Bound onto idt_core after the module
`timescale 1ns/1ps
module idt_core_checker
   import idt_pkg::*;
#(
   parameter logic [6:0] TIMER_ADDR = 7'h01,
   parameter logic [6:0] PCL_ADDR   = 7'h02,
   parameter logic [6:0] PORT_ADDR  = 7'h06
)
(
   input wire logic                    ref_clk,
   input wire logic                    sys_rst,
   input wire logic [13:0]             instrWord,
   input wire logic                    skipTrue,
   input wire logic                    prescalerOnTimer,
   input wire logic [7:0]              fileData,
   input wire logic [7:0]              portPins,
   input wire idt_pkg::idt_decode_type decoded,
   input wire logic                    fetchStrobe,
   input wire logic                    cycleStart,
   input wire logic                    execStrobe,
   input wire logic                    nopCycle,
   input wire logic                    writeAccum,
   input wire logic                    writeFile,
   input wire logic                    prescalerClear,
   input wire logic                    pcAltered,
   input wire logic                    illegalOp,
   input wire logic [7:0]              srcOperand
);
   // Single domain, reset silences every check
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // Cycle framing and result routing
   property p_fetch_period; fetchStrobe |=> !fetchStrobe [*3] ##1 fetchStrobe; endproperty
   a_fetch_period: assert property (p_fetch_period) else $error("fetch period wrong");
   property p_cycle_start; fetchStrobe |=> cycleStart; endproperty
   a_cycle_start: assert property (p_cycle_start) else $error("cycle start missing");
   property p_exec_align; execStrobe |-> fetchStrobe; endproperty
   a_exec_align: assert property (p_exec_align) else $error("exec off boundary");
   property p_write_gate;
      (writeAccum || writeFile) |-> execStrobe && !nopCycle && !illegalOp;
   endproperty
   a_write_gate: assert property (p_write_gate) else $error("write outside exec");
   property p_route;
      execStrobe && !nopCycle && decoded.fmt == FMT_BYTE && decoded.readsFile
         |-> writeFile == decoded.toFile && writeAccum == !decoded.toFile;
   endproperty
   a_route: assert property (p_route) else $error("destination routing wrong");
   property p_fields;
      cycleStart && !nopCycle |=> decoded.fileAddr == $past(instrWord[6:0], 2)
         && decoded.bitPos == $past(instrWord[9:7], 2) && decoded.lit11 == $past(instrWord[10:0], 2);
   endproperty
   a_fields: assert property (p_fields) else $error("field slices wrong");
   property p_flush;
      execStrobe && !nopCycle && (pcAltered || decoded.maySkip && $past(skipTrue)) |=> nopCycle;
   endproperty
   a_flush: assert property (p_flush) else $error("flush cycle missing");
   property p_no_flush;
      execStrobe && !nopCycle && !pcAltered && !(decoded.maySkip && $past(skipTrue))
         |=> !nopCycle;
   endproperty
   a_no_flush: assert property (p_no_flush) else $error("spurious flush");
   property p_prescale;
      execStrobe |-> prescalerClear == (writeFile && decoded.fileAddr == TIMER_ADDR
         && $past(prescalerOnTimer));
   endproperty
   a_prescale: assert property (p_prescale) else $error("prescaler clear wrong");
   property p_illegal; execStrobe && illegalOp |-> !writeFile && !pcAltered; endproperty
   a_illegal: assert property (p_illegal) else $error("unused word acted");
   // Main scenarios reached
   c_flow: cover property (execStrobe && pcAltered);
   c_clear: cover property (prescalerClear);
   c_bad: cover property (execStrobe && illegalOp);
endmodule

bind idt_core idt_core_checker #(.TIMER_ADDR(TIMER_ADDR), .PCL_ADDR(PCL_ADDR),
   .PORT_ADDR(PORT_ADDR)) i_idt_core_checker (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .instrWord(instrWord), .skipTrue(skipTrue), .prescalerOnTimer(prescalerOnTimer),
   .fileData(fileData), .portPins(portPins), .decoded(decoded), .fetchStrobe(fetchStrobe),
   .cycleStart(cycleStart), .execStrobe(execStrobe), .nopCycle(nopCycle),
   .writeAccum(writeAccum), .writeFile(writeFile), .prescalerClear(prescalerClear),
   .pcAltered(pcAltered), .illegalOp(illegalOp), .srcOperand(srcOperand));

// File: verification/instruction_decode_timing_tb_top.sv
// Purpose: Self-checking bench for the decode and timing core
// Assumes: Each word is presented one fetch ahead of its use
// Notes:   Expected effects come from an independent encoding table
`timescale 1ns/1ps
module instruction_decode_timing_tb_top;
   import idt_pkg::*;
   typedef struct packed {
      logic [13:0] w;
      logic [2:0]  f;
      logic [5:0]  op;
   } idt_req_type;
   typedef struct packed {
      logic [13:0] w;
      logic        fl, wa, wf, pclr, pc, il, ms, rd, fc, oc;
      logic [1:0]  fmt;
      logic [5:0]  op;
      logic [7:0]  src;
   } idt_exp_type;
   localparam logic [6:0] TMR_AD = 7'h01;
   localparam logic [6:0] PCL_AD = 7'h02;
   localparam logic [6:0] PRT_AD = 7'h06;
   logic           ref_clk, sys_rst, skipTrue, prescalerOnTimer, flushNext;
   logic [13:0]    instrWord, rw;
   logic [7:0]     fileData, portPins, srcOperand, fd;
   idt_decode_type decoded;
   logic           fetchStrobe, cycleStart, execStrobe, nopCycle, writeAccum, writeFile;
   logic           prescalerClear, pcAltered, illegalOp;
   int             n_mismatch, num_checks, cyc, seed;
   idt_req_type    held, reqQ[$];
   idt_exp_type    e, m, expQ[$];

   idt_core #(.TIMER_ADDR(TMR_AD), .PCL_ADDR(PCL_AD), .PORT_ADDR(PRT_AD)) i_idt_core (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .instrWord(instrWord), .skipTrue(skipTrue),
      .prescalerOnTimer(prescalerOnTimer), .fileData(fileData), .portPins(portPins),
      .decoded(decoded), .fetchStrobe(fetchStrobe), .cycleStart(cycleStart),
      .execStrobe(execStrobe), .nopCycle(nopCycle), .writeAccum(writeAccum),
      .writeFile(writeFile), .prescalerClear(prescalerClear), .pcAltered(pcAltered),
      .illegalOp(illegalOp), .srcOperand(srcOperand));

   // Oscillator clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Compare one result, count and report a mismatch
   task automatic chk(string n, logic [31:0] x, logic [31:0] g);
      num_checks++;
      if (g !== x) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h got %h", n, x, g);
      end
   endtask

   // Queue one word with its opcode check, prescaler and skip flags
   task automatic put(logic [13:0] w, logic [2:0] f, idt_op_type op);
      reqQ.push_back({w, f, 6'(op)});
   endtask

   // Reference effects of one word; f holds opcode check, prescaler, skip
   function automatic idt_exp_type expect_of(idt_req_type r, logic fl, logic [7:0] d);
      idt_exp_type x;
      logic [13:0] w;
      w = r.w;
      x = '0;
      {x.w, x.fl, x.op, x.oc} = {w, fl, r.op, r.f[2]};
      x.fc = (w[13:12] != 2'h0);
      x.fmt = (w[13:12] == 2'h1) ? FMT_BIT : FMT_LITCTL;
      x.src = (w[6:0] == PRT_AD) ? portPins : d;
      if (w[13:12] == 2'h0 && w[11:8] >= 4'h2) begin
         x.fmt = FMT_BYTE;
         {x.fc, x.rd, x.wa, x.wf} = {2'h3, !w[7], w[7]};
         x.ms = (w[11:8] == 4'hB) || (w[11:8] == 4'hF);
      end else begin
         casez (w)
            14'b00_000?_1???_????: x.wf = 1'b1;
            14'h0103: x.wa = 1'b1;
            14'b00_0000_0??0_0000, 14'h0063, 14'h0064: x.wa = 1'b0;
            14'h0008, 14'h0009, 14'b10_????_????_????: x.pc = 1'b1;
            14'b01_????_????_????: {x.rd, x.wf, x.ms} = {1'b1, !w[11], w[11]};
            14'b11_01??_????_????: {x.wa, x.pc} = 2'h3;
            14'b11_????_????_????: x.wa = 1'b1;
            default: x.il = 1'b1;
         endcase
      end
      x.pc = x.pc || (x.wf && w[6:0] == PCL_AD);
      x.pclr = x.wf && w[6:0] == TMR_AD && r.f[1];
      if (fl) {x.wa, x.wf, x.pclr, x.pc, x.ms} = '0;
      return x;
   endfunction

   // Counts line, verdict and end of run
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Drain the word queue and let the pipe empty
   task automatic wait_idle(string n);
      while (reqQ.size() != 0) @(posedge ref_clk);
      repeat (12) @(posedge ref_clk);
      $display("%s test done", n);
   endtask

   // Driver: at each taking edge note the word, present the next one
   always @(posedge ref_clk) begin
      if (!sys_rst && fetchStrobe === 1'b1) begin
         fd = 8'($random(seed));
         e = expect_of(held, flushNext, fd);
         expQ.push_back(e);
         flushNext = e.pc || (e.ms && held.f[0]);
         skipTrue <= held.f[0];
         prescalerOnTimer <= held.f[1];
         fileData <= fd;
         held = '0;
         if (reqQ.size() != 0) held = reqQ.pop_front();
         instrWord <= held.w;
      end
   end

   // Monitor: one note per executed cycle
   always @(negedge ref_clk) begin
      if (execStrobe === 1'b1) begin
         m = expQ.pop_front();
         chk("effects", 32'({m.fl, m.wa, m.wf, m.pclr}),
             32'({nopCycle, writeAccum, writeFile, prescalerClear}));
         if (!m.fl) begin
            chk("flow", 32'({m.pc, m.il, m.ms, m.rd}),
                32'({pcAltered, illegalOp, decoded.maySkip, decoded.readsFile}));
            chk("fields", 32'({m.w[6:0], m.w[7], m.w[9:7], m.w[7:0], m.w[10:0]}),
                32'({decoded.fileAddr, decoded.toFile, decoded.bitPos, decoded.lit8,
                     decoded.lit11}));
            if (m.fc) chk("format", 32'(m.fmt), 32'(decoded.fmt));
            if (m.oc) chk("operation", 32'(m.op), 32'(decoded.op));
            if (m.rd) chk("source", 32'(m.src), 32'(srcOperand));
         end
      end
   end

   // Hang guard
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         n_mismatch++;
         results();
      end
   end

   // Reset, directed words, then random words
   initial begin
      seed = 32'hB099;
      sys_rst = 1'b1;
      {skipTrue, prescalerOnTimer, instrWord, fileData} = '0;
      portPins = 8'($random(seed));
      held = '0;
      flushNext = 1'b0;
      expQ.push_back(expect_of(held, 1'b1, 8'h00));
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      put(14'h3055, 3'h4, OP_MOVLW);
      put(14'h3355, 3'h4, OP_MOVLW);
      put(14'h3E12, 3'h4, OP_ADDLW);
      put(14'h3F12, 3'h4, OP_ADDLW);
      put(14'h0060, 3'h4, OP_NOP);
      put(14'h077F, 3'h4, OP_ADDWF);
      put(14'h0780, 3'h4, OP_ADDWF);
      put(14'h0BA0, 3'h5, OP_DECSZ);
      put(14'h3011, 3'h0, OP_BAD);
      put(14'h1FFF, 3'h4, OP_BTFSS);
      put(14'h17FF, 3'h4, OP_BSF);
      put(14'h2ABC, 3'h4, OP_GOTO);
      put(14'h2FFF, 3'h0, OP_BAD);
      put(14'h2001, 3'h4, OP_CALL);
      put(14'h0000, 3'h0, OP_BAD);
      put(14'h0082, 3'h4, OP_MOVWF);
      put(14'h0000, 3'h0, OP_BAD);
      put(14'h0081, 3'h6, OP_MOVWF);
      put(14'h0081, 3'h4, OP_MOVWF);
      put(14'h0A86, 3'h4, OP_INCF);
      put(14'h0062, 3'h4, OP_BAD);
      put(14'h0066, 3'h4, OP_BAD);
      put(14'h0103, 3'h4, OP_CLRW);
      put(14'h3477, 3'h4, OP_RETLW);
      wait_idle("directed");
      repeat (200) begin
         rw = 14'($random(seed));
         if (rw[13:9] == 5'b11101) rw[9] = 1'b0;
         put(rw, 3'($random(seed)) & 3'h3, OP_BAD);
      end
      wait_idle("random");
      results();
   end
endmodule
